// file: logic/vdsfd_pkg.sv
// Package for the video decoder status, format and decimation registers.
// Assumes byte-wide registers on lane 0 of a 32-bit memory-mapped port.
package vdsfd_pkg;
  // Register byte offsets within the 4 kB window
  localparam logic [11:0] VDSFD_OFS_DEVICE_STATUS = 12'h000;
  localparam logic [11:0] VDSFD_OFS_INPUT_FORMAT = 12'h004;
  localparam logic [11:0] VDSFD_OFS_TEMPORAL_DECIMATION = 12'h008;
  localparam int VDSFD_ADDR_LSB = 2;

  // Reset values
  localparam logic [7:0] VDSFD_RST_DEVICE_STATUS = 8'h00;
  localparam logic [7:0] VDSFD_RST_INPUT_FORMAT = 8'h58;
  localparam logic [7:0] VDSFD_RST_TEMPORAL_DECIMATION = 8'h00;

  // Device status bit positions
  localparam int VDSFD_ST_PRESENT = 7;
  localparam int VDSFD_ST_HLOCK = 6;
  localparam int VDSFD_ST_FIELD = 5;
  localparam int VDSFD_ST_LINESTD = 4;
  localparam int VDSFD_ST_PLL = 2;
  localparam int VDSFD_ST_LUMA = 1;
  localparam int VDSFD_ST_CHROMA = 0;

  // Input format fields
  localparam int VDSFD_IF_MBZ = 7;
  localparam int VDSFD_IF_SEL_HI = 6;
  localparam int VDSFD_IF_SEL_LO = 5;
  localparam int VDSFD_IF_RO_HI = 4;
  localparam int VDSFD_IF_RO_LO = 3;
  localparam int VDSFD_IF_FMT_HI = 2;
  localparam logic [1:0] VDSFD_IF_RO_VALUE = 2'h3;

  // Temporal decimation fields
  localparam int VDSFD_TD_BY_FIELD = 7;
  localparam int VDSFD_TD_START_PAR = 6;
  localparam int VDSFD_TD_CNT_HI = 5;

  // Run lengths and decimation periods
  localparam int VDSFD_MISS_LINES = 31;
  localparam int VDSFD_HLOCK_LINES = 32;
  localparam int VDSFD_STD_FIELDS = 32;
  localparam logic [6:0] VDSFD_PERIOD_525 = 7'h3C;
  localparam logic [6:0] VDSFD_PERIOD_625 = 7'h32;

  // Input standard codes
  typedef enum logic [2:0] {
    VDSFD_FMT_AUTO = 3'b000,
    VDSFD_FMT_NTSC_M = 3'b001,
    VDSFD_FMT_NTSC_JP = 3'b010,
    VDSFD_FMT_PAL_BDGHI = 3'b011,
    VDSFD_FMT_PAL_M = 3'b100,
    VDSFD_FMT_PAL_N = 3'b101,
    VDSFD_FMT_SECAM = 3'b110,
    VDSFD_FMT_PAL_NC = 3'b111
  } vdsfd_fmt_e;
endpackage

// file: logic/vdsfd_run_filter.sv
// Run-length filter: a flag that follows its sample only after a full run.
// Assumes samples are presented as one-cycle strobes on clk.
`timescale 1ns/1ps
module vdsfd_run_filter #(
  parameter int RUN = 32
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Sample strobe and value
  input wire logic sample_stb,
  input wire logic sample_val,
  // Filtered flag
  output logic flag
);
  import vdsfd_pkg::*;

  localparam int CW = $clog2(RUN + 1);
  localparam logic [CW-1:0] RUN_LAST = CW'(RUN - 1);

  typedef struct packed {
    logic flag;
    logic [CW-1:0] cnt;
  } vdsfd_run_s;

  vdsfd_run_s st_q;
  vdsfd_run_s st_d;

  always_comb begin
    st_d = st_q;
    if (sample_stb) begin
      // A sample agreeing with the flag breaks the run
      if (sample_val == st_q.flag) begin
        st_d.cnt = '0;
      end else if (st_q.cnt == RUN_LAST) begin
        st_d.flag = sample_val;
        st_d.cnt = '0;
      end else begin
        st_d.cnt = st_q.cnt + CW'(1);
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign flag = st_q.flag;
endmodule

// file: logic/vdsfd_regs.sv
// Device status, input format and temporal decimation registers.
// Assumes a memory-mapped slave port with AD[11:2] and byte enables,
// and decoder-core indications synchronous to clk.
`timescale 1ns/1ps
module vdsfd_regs (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Register port
  input wire logic [11:2] reg_addr,
  input wire logic [3:0] reg_be,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_wdata,
  output logic [31:0] reg_rdata,
  output logic reg_rvalid,
  // Decoder core indications
  input wire logic line_stb,
  input wire logic line_sync_ok,
  input wire logic line_hsync_ok,
  input wire logic field_stb,
  input wire logic field_even,
  input wire logic field_625,
  input wire logic pll_unlock,
  input wire logic luma_ovf,
  input wire logic chroma_ovf,
  // Decoder controls
  output logic [1:0] video_input_index,
  output vdsfd_pkg::vdsfd_fmt_e format_sel,
  output logic format_auto,
  output logic field_keep,
  // Live status
  output logic video_present_flag,
  output logic horizontal_lock_flag,
  output logic line_count_standard_flag
);
  import vdsfd_pkg::*;

  localparam int MW = $clog2(VDSFD_MISS_LINES + 1);
  localparam logic [MW-1:0] MISS_LAST = MW'(VDSFD_MISS_LINES - 1);
  localparam logic [9:0] IDX_STATUS = VDSFD_OFS_DEVICE_STATUS[11:VDSFD_ADDR_LSB];
  localparam logic [9:0] IDX_INPUT_FORMAT = VDSFD_OFS_INPUT_FORMAT[11:VDSFD_ADDR_LSB];
  localparam logic [9:0] IDX_TEMPORAL_DECIMATION = VDSFD_OFS_TEMPORAL_DECIMATION[11:VDSFD_ADDR_LSB];

  typedef struct packed {
    // Sampled decoder indications
    logic line_stb;
    logic sync_ok;
    logic hsync_ok;
    logic field_stb;
    logic field_even;
    logic field_625;
    logic pll_unlock;
    logic luma_ovf;
    logic chroma_ovf;
    // Presence tracking
    logic present;
    logic [MW-1:0] miss_cnt;
    // Sticky overflow flags
    logic luma_flag;
    logic chroma_flag;
    // Writable registers
    logic [7:0] input_format;
    logic [7:0] temporal_decimation;
    // Decimator
    logic armed;
    logic [6:0] acc;
    logic keep;
    // Read port
    logic [31:0] rdata;
    logic rvalid;
  } vdsfd_state_s;

  vdsfd_state_s st_q;
  vdsfd_state_s st_d;

  logic hlock;
  logic line_std;
  logic wr_lane0;
  logic wr_status;
  logic wr_input_format;
  logic wr_temporal_decimation;
  logic [7:0] status_byte;
  logic [7:0] rd_byte;
  logic [6:0] period;
  logic [6:0] sum;
  logic [6:0] eff_cnt;
  logic [5:0] dec_cnt;
  logic start_par;
  logic unit_start;
  // Address decode
  logic hit_status;
  logic hit_input_format;
  logic hit_temporal_decimation;
  // Presence and decimator next values; select and format codes
  logic video_present_flag_next;
  logic [MW-1:0] miss_next;
  logic dec_keep;
  logic dec_armed;
  logic [6:0] dec_acc;
  logic [1:0] sel_code;
  logic [2:0] fmt_code;

  // Horizontal lock, both directions through the same run filter
  vdsfd_run_filter #(
    .RUN(VDSFD_HLOCK_LINES)
  ) u_hlock (
    .clk(clk),
    .rst_b(rst_b),
    .sample_stb(st_q.line_stb),
    .sample_val(st_q.hsync_ok),
    .flag(hlock)
  );

  // Line standard settles only after a run of equal fields
  vdsfd_run_filter #(
    .RUN(VDSFD_STD_FIELDS)
  ) u_linestd (
    .clk(clk),
    .rst_b(rst_b),
    .sample_stb(st_q.field_stb),
    .sample_val(st_q.field_625),
    .flag(line_std)
  );

  // Word decode shared by reads and writes; one register per word
  assign hit_status = (reg_addr == IDX_STATUS);
  assign hit_input_format = (reg_addr == IDX_INPUT_FORMAT);
  assign hit_temporal_decimation = (reg_addr == IDX_TEMPORAL_DECIMATION);

  // Only lane 0 carries data; a write without it stores nothing
  assign wr_lane0 = reg_wr && reg_be[0];
  assign wr_status = wr_lane0 && hit_status;
  assign wr_input_format = wr_lane0 && hit_input_format;
  assign wr_temporal_decimation = wr_lane0 && hit_temporal_decimation;

  assign dec_cnt = st_q.temporal_decimation[VDSFD_TD_CNT_HI:0];
  assign start_par = st_q.temporal_decimation[VDSFD_TD_START_PAR];
  assign period = line_std ? VDSFD_PERIOD_625 : VDSFD_PERIOD_525;
  // Counts above the period drop every unit; keeps the accumulator below it
  assign eff_cnt = ({1'b0, dec_cnt} > period) ? period : {1'b0, dec_cnt};
  assign sum = st_q.acc + eff_cnt;

  // Field mode: every field is a unit; frame mode: the aligned field opens one
  assign unit_start = st_q.temporal_decimation[VDSFD_TD_BY_FIELD] ||
                      (st_q.field_even == start_par);

  // Status byte, assembled from live and sticky state
  always_comb begin
    status_byte = VDSFD_RST_DEVICE_STATUS;
    status_byte[VDSFD_ST_PRESENT] = st_q.present;
    status_byte[VDSFD_ST_HLOCK] = hlock;
    status_byte[VDSFD_ST_FIELD] = st_q.field_even;
    status_byte[VDSFD_ST_LINESTD] = line_std;
    status_byte[VDSFD_ST_PLL] = st_q.pll_unlock;
    status_byte[VDSFD_ST_LUMA] = st_q.luma_flag;
    status_byte[VDSFD_ST_CHROMA] = st_q.chroma_flag;
  end

  // Read mux; unused offsets answer zero
  always_comb begin
    rd_byte = 8'h00;
    if (hit_status) begin
      rd_byte = status_byte;
    end else if (hit_input_format) begin
      rd_byte = st_q.input_format;
      rd_byte[VDSFD_IF_RO_HI:VDSFD_IF_RO_LO] = VDSFD_IF_RO_VALUE;
    end else if (hit_temporal_decimation) begin
      rd_byte = st_q.temporal_decimation;
    end
  end

  // Presence run: a single synced line restores presence at once
  always_comb begin
    video_present_flag_next = st_q.present;
    miss_next = st_q.miss_cnt;
    if (st_q.line_stb) begin
      if (st_q.sync_ok) begin
        video_present_flag_next = 1'b1;
        miss_next = '0;
      end else if (st_q.miss_cnt == MISS_LAST) begin
        video_present_flag_next = 1'b0;
        miss_next = '0;
      end else begin
        miss_next = st_q.miss_cnt + MW'(1);
      end
    end
  end

  // Decimator decision for one sampled field; applied only on field strobes
  always_comb begin
    dec_keep = st_q.keep;
    dec_armed = st_q.armed;
    dec_acc = st_q.acc;
    if (dec_cnt == 6'h00) begin
      dec_keep = 1'b1;
      dec_armed = 1'b0;
    end else if (!st_q.armed && (st_q.field_even != start_par)) begin
      // Fields ahead of the aligned parity pass untouched
      dec_keep = 1'b1;
    end else if (unit_start) begin
      if (!st_q.armed) begin
        // Aligned first unit drops; a leftover sum must not double the next drop
        dec_armed = 1'b1;
        dec_keep = 1'b0;
        dec_acc = 7'(eff_cnt - 7'd1);
      end else if (sum >= period) begin
        dec_keep = 1'b0;
        dec_acc = 7'(sum - period);
      end else begin
        dec_keep = 1'b1;
        dec_acc = sum;
      end
    end
    // Second field of a frame inherits the frame decision
  end

  always_comb begin
    st_d = st_q;

    // One register stage on every decoder indication
    st_d.line_stb = line_stb;
    st_d.sync_ok = line_sync_ok;
    st_d.hsync_ok = line_hsync_ok;
    st_d.field_stb = field_stb;
    st_d.field_even = field_even;
    st_d.field_625 = field_625;
    st_d.pll_unlock = pll_unlock;
    st_d.luma_ovf = luma_ovf;
    st_d.chroma_ovf = chroma_ovf;

    // Presence run
    st_d.present = video_present_flag_next;
    st_d.miss_cnt = miss_next;

    // Sticky overflow flags; a new overflow beats a same-cycle clear
    if (wr_status) begin
      st_d.luma_flag = 1'b0;
      st_d.chroma_flag = 1'b0;
    end
    if (st_q.luma_ovf) begin
      st_d.luma_flag = 1'b1;
    end
    if (st_q.chroma_ovf) begin
      st_d.chroma_flag = 1'b1;
    end

    // Input format; bits 4:3 are not stored
    if (wr_input_format) begin
      st_d.input_format = reg_wdata[7:0];
      st_d.input_format[VDSFD_IF_RO_HI:VDSFD_IF_RO_LO] = VDSFD_IF_RO_VALUE;
    end

    // Decimation; a rewrite re-aligns on the next matching field
    if (wr_temporal_decimation) begin
      st_d.temporal_decimation = reg_wdata[7:0];
      st_d.armed = 1'b0;
    end else if (st_q.field_stb) begin
      st_d.keep = dec_keep;
      st_d.armed = dec_armed;
      st_d.acc = dec_acc;
    end

    // Registered read data, one cycle after the request
    st_d.rvalid = reg_rd;
    if (reg_rd) begin
      st_d.rdata = 32'h0000_0000;
      if (reg_be[0]) begin
        st_d.rdata[7:0] = rd_byte;
      end
    end
  end

  // Reset gives zero status, 0x58 format and zero decimation
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      st_q <= '0;
      st_q.input_format <= VDSFD_RST_INPUT_FORMAT;
      st_q.temporal_decimation <= VDSFD_RST_TEMPORAL_DECIMATION;
      st_q.keep <= 1'b1;
    end else begin
      st_q <= st_d;
    end
  end

  // Physical input from the select code
  assign sel_code = st_q.input_format[VDSFD_IF_SEL_HI:VDSFD_IF_SEL_LO];
  always_comb begin
    unique case (sel_code)
      2'b00: video_input_index = 2'd3;
      2'b01: video_input_index = 2'd2;
      2'b10: video_input_index = 2'd0;
      2'b11: video_input_index = 2'd1;
    endcase
  end

  // Effective standard; automatic mode only tells 525 from 625
  // Field code as stored; every code is a legal standard
  assign fmt_code = st_q.input_format[VDSFD_IF_FMT_HI:0];
  always_comb begin
    format_auto = (fmt_code == VDSFD_FMT_AUTO);
    if (format_auto) begin
      format_sel = line_std ? VDSFD_FMT_PAL_BDGHI : VDSFD_FMT_NTSC_M;
    end else begin
      format_sel = vdsfd_fmt_e'(fmt_code);
    end
  end

  assign reg_rdata = st_q.rdata;
  assign reg_rvalid = st_q.rvalid;
  assign field_keep = st_q.keep;
  assign video_present_flag = st_q.present;
  assign horizontal_lock_flag = hlock;
  assign line_count_standard_flag = line_std;
endmodule

// file: tb/vdsfd_regs_checker.sv
// Port checker for the status, format and decimation registers.
// Assumes it is bound to vdsfd_regs and sees only that module's ports.
`timescale 1ns/1ps
module vdsfd_regs_checker
  import vdsfd_pkg::*;
(
  // Clock, reset and register port
  input wire logic clk, rst_b, reg_wr, reg_rd, reg_rvalid,
  input wire logic [11:2] reg_addr,
  input wire logic [3:0] reg_be,
  input wire logic [31:0] reg_wdata, reg_rdata,
  // Decoder side
  input wire logic line_stb, line_sync_ok, line_hsync_ok, field_stb, field_even, field_625,
  input wire logic pll_unlock, luma_ovf, chroma_ovf, format_auto, field_keep,
  input wire logic video_present_flag, horizontal_lock_flag, line_count_standard_flag,
  input wire logic [1:0] video_input_index,
  input vdsfd_fmt_e format_sel
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  logic st_rd;
  assign st_rd = reg_rd && reg_addr == 10'h000 && reg_be[0];

  chk_upper_lanes: assert property (reg_rvalid |-> reg_rdata[31:8] == 24'h00_0000)
    else $error("upper byte lanes not zero");
  chk_luma_sticky: assert property (luma_ovf ##2 (st_rd && !reg_wr) |=> reg_rdata[1])
    else $error("luma overflow not reported");
  chk_field_live: assert property (st_rd |=> reg_rdata[5] == $past(field_even, 2))
    else $error("field bit does not follow field parity");
  chk_select_map: assert property (reg_rvalid && $past(reg_addr) == 10'h001 && $past(reg_be[0])
    && !$past(reg_wr) |-> reg_rdata[4:3] == 2'b11 && video_input_index ==
    {~reg_rdata[6], ~(reg_rdata[6] ^ reg_rdata[5])})
    else $error("input select mapping wrong");
  chk_auto_format: assert property (format_auto |-> format_sel ==
    (line_count_standard_flag ? VDSFD_FMT_PAL_BDGHI : VDSFD_FMT_NTSC_M))
    else $error("automatic format does not follow line standard");
  chk_present_cause: assert property ($rose(video_present_flag) |->
    $past(line_stb, 2) && $past(line_sync_ok, 2))
    else $error("presence set without a synced line");
  chk_hlock_cause: assert property ($changed(horizontal_lock_flag) |-> $past(line_stb, 2)
    && $past(line_hsync_ok, 2) == horizontal_lock_flag)
    else $error("lock flag moved without a matching line");
  chk_std_cause: assert property ($changed(line_count_standard_flag) |-> $past(field_stb, 2)
    && $past(field_625, 2) == line_count_standard_flag)
    else $error("line standard moved without a matching field");
  chk_keep_moves: assert property ($changed(field_keep) |-> $past(field_stb, 2))
    else $error("keep level moved between fields");
endmodule

// file: tb/vdsfd_host.sv
// Host software model: lane 0 byte writes and all-lane reads on the register port.
// Assumes one-cycle read latency answered by reg_rvalid.
`timescale 1ns/1ps
module vdsfd_host
  import vdsfd_pkg::*;
(
  // Clock
  input wire logic clk,
  // Register port
  output logic [11:2] reg_addr,
  output logic [3:0] reg_be,
  output logic reg_wr,
  output logic reg_rd,
  output logic [31:0] reg_wdata,
  input wire logic [31:0] reg_rdata,
  input wire logic reg_rvalid
);
  initial begin
    {reg_addr, reg_be, reg_wr, reg_rd, reg_wdata} = '0;
  end
  task automatic wr(input logic [11:0] ofs, input logic [7:0] d, input logic [3:0] be = 4'h1);
    @(posedge clk);
    #1;
    reg_addr = ofs[11:2];
    reg_be = be;
    reg_wdata = {24'h00_0000, (ofs == VDSFD_OFS_INPUT_FORMAT) ? {1'b0, d[6:0]} : d};
    reg_wr = 1'b1;
    @(posedge clk);
    #1;
    reg_wr = 1'b0;
    // Released port shows no stale value
    reg_addr = ~reg_addr;
    reg_wdata = ~reg_wdata;
  endtask
  task automatic rd(input logic [11:0] ofs, output logic [31:0] d);
    int n;
    @(posedge clk);
    #1;
    reg_addr = ofs[11:2];
    reg_be = 4'hF;
    reg_rd = 1'b1;
    @(posedge clk);
    #1;
    reg_rd = 1'b0;
    reg_addr = ~reg_addr;
    n = 0;
    while (reg_rvalid !== 1'b1 && n < 4) begin
      @(posedge clk);
      #1;
      n++;
    end
    d = (reg_rvalid === 1'b1) ? reg_rdata : 32'hxxxx_xxxx;
  endtask
  // Clock source may only move to the PLL once this reports ok
  task automatic settle_pll(input int tries, output logic ok);
    logic [31:0] s;
    ok = 1'b0;
    for (int i = 0; i < tries && !ok; i++) begin
      rd(VDSFD_OFS_DEVICE_STATUS, s);
      if (s[VDSFD_ST_PLL] === 1'b0) ok = 1'b1;
      else wr(VDSFD_OFS_DEVICE_STATUS, 8'h04);
    end
  endtask
endmodule

// file: tb/tb_top.sv
// Testbench for the status, format and decimation registers.
// Assumes the host model owns the register port; decoder inputs are driven here.
`timescale 1ns/1ps
module tb_top;
  import vdsfd_pkg::*;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic line_stb, line_sync_ok, line_hsync_ok, field_stb, field_even, field_625;
  logic pll_unlock, luma_ovf, chroma_ovf, reg_wr, reg_rd, reg_rvalid, ok, k;
  logic format_auto, field_keep, video_present_flag, horizontal_lock_flag;
  logic line_count_standard_flag;
  logic [11:2] reg_addr;
  logic [3:0] reg_be;
  logic [31:0] reg_wdata, reg_rdata;
  logic [1:0] video_input_index;
  logic [1:0] idx_tab [4] = '{2'd3, 2'd2, 2'd0, 2'd1};
  vdsfd_fmt_e format_sel;
  int errors = 0;
  int tests_run = 0;
  int d;
  always #5 clk = ~clk;

  vdsfd_regs DUT (.clk(clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_be(reg_be),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .line_stb(line_stb), .line_sync_ok(line_sync_ok),
    .line_hsync_ok(line_hsync_ok), .field_stb(field_stb), .field_even(field_even),
    .field_625(field_625), .pll_unlock(pll_unlock), .luma_ovf(luma_ovf),
    .chroma_ovf(chroma_ovf), .video_input_index(video_input_index),
    .format_sel(format_sel), .format_auto(format_auto), .field_keep(field_keep),
    .video_present_flag(video_present_flag), .horizontal_lock_flag(horizontal_lock_flag),
    .line_count_standard_flag(line_count_standard_flag));
  vdsfd_host host (.clk(clk), .reg_addr(reg_addr), .reg_be(reg_be), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid));

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic results();
    if (errors == 0 && tests_run > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic rchk(input logic [11:0] ofs, input logic [31:0] exp, input string what);
    logic [31:0] v;
    host.rd(ofs, v);
    check(what, v, exp);
  endtask
  // n line or field strobes, one by default; flags settle on the second edge after each is driven
  task automatic strobe(input logic fld, input logic a, input logic b, input int n = 1);
    repeat (n) begin
      @(posedge clk);
      #1;
      if (fld) {field_stb, field_even, field_625} = {1'b1, a, b};
      else {line_stb, line_sync_ok, line_hsync_ok} = {1'b1, a, b};
      @(posedge clk);
      #1;
      {field_stb, line_stb} = 2'b00;
      repeat (2) @(posedge clk);
      #1;
    end
  endtask

  task automatic t_reset();
    rchk(VDSFD_OFS_DEVICE_STATUS, 32'h0000_0000, "status");
    rchk(VDSFD_OFS_INPUT_FORMAT, 32'h0000_0058, "format reg");
    rchk(VDSFD_OFS_TEMPORAL_DECIMATION, 32'h0000_0000, "decim reg");
    rchk(12'h0FC, 32'h0000_0000, "unmapped");
    check("index", video_input_index, 2'd0);
  endtask
  task automatic t_format();
    for (int i = 0; i < 8; i++) begin
      host.wr(VDSFD_OFS_INPUT_FORMAT, {1'b0, 2'(i), 2'b00, 3'(i)});
      rchk(VDSFD_OFS_INPUT_FORMAT, {24'h00_0000, 1'b0, 2'(i), 2'b11, 3'(i)}, "fmt");
      check("index", video_input_index, idx_tab[i % 4]);
      check("auto", format_auto, i == 0);
      check("std", format_sel, (i == 0) ? 32'(VDSFD_FMT_NTSC_M) : 32'(i));
    end
    host.wr(VDSFD_OFS_INPUT_FORMAT, 8'h00, 4'h0);
    rchk(VDSFD_OFS_INPUT_FORMAT, 32'h0000_007F, "lane off");
    host.wr(VDSFD_OFS_INPUT_FORMAT, 8'h40);
  endtask
  task automatic t_overflow();
    @(posedge clk);
    #1 luma_ovf = 1'b1;
    @(posedge clk);
    #1 luma_ovf = 1'b0;
    rchk(VDSFD_OFS_DEVICE_STATUS, 32'h0000_0002, "luma");
    chroma_ovf = 1'b1;
    @(posedge clk);
    #1 chroma_ovf = 1'b0;
    rchk(VDSFD_OFS_DEVICE_STATUS, 32'h0000_0003, "sticky");
    host.wr(VDSFD_OFS_DEVICE_STATUS, 8'h00);
    rchk(VDSFD_OFS_DEVICE_STATUS, 32'h0000_0000, "cleared");
  endtask
  task automatic t_sync();
    strobe(0, 1, 1);
    check("present", video_present_flag, 1);
    strobe(0, 0, 0, 30);
    check("present 30", video_present_flag, 1);
    strobe(0, 0, 0);
    check("absent 31", video_present_flag, 0);
    strobe(0, 1, 1, 31);
    check("lock 31", horizontal_lock_flag, 0);
    strobe(0, 1, 1);
    check("lock 32", horizontal_lock_flag, 1);
    host.wr(VDSFD_OFS_DEVICE_STATUS, 8'h00);
    check("lock kept", horizontal_lock_flag, 1);
    strobe(0, 1, 0, 31);
    strobe(0, 1, 1);
    strobe(0, 1, 0, 31);
    check("lock held", horizontal_lock_flag, 1);
    strobe(0, 1, 0);
    check("lock lost", horizontal_lock_flag, 0);
  endtask
  task automatic t_std();
    for (int i = 0; i < 31; i++) strobe(1, i[0], 1);
    check("std 31", line_count_standard_flag, 0);
    strobe(1, 1, 1);
    rchk(VDSFD_OFS_DEVICE_STATUS, 32'h0000_00B0, "even 625");
    check("auto 625", format_sel, VDSFD_FMT_PAL_BDGHI);
    strobe(1, 0, 1);
    rchk(VDSFD_OFS_DEVICE_STATUS, 32'h0000_0090, "odd");
    pll_unlock = 1'b1;
    host.settle_pll(3, ok);
    check("pll stuck", ok, 0);
    rchk(VDSFD_OFS_DEVICE_STATUS, 32'h0000_0094, "pll");
    pll_unlock = 1'b0;
    host.settle_pll(3, ok);
    check("pll ok", ok, 1);
  endtask
  task automatic t_decim();
    host.wr(VDSFD_OFS_TEMPORAL_DECIMATION, 8'h99);
    strobe(1, 1, 1);
    check("even kept", field_keep, 1);
    d = 0;
    for (int i = 0; i < 100; i++) begin
      strobe(1, i[0], 1);
      if (i == 0) check("odd first", field_keep, 0);
      d += !field_keep;
    end
    check("drops", 32'(d >= 49 && d <= 51), 1);
    host.wr(VDSFD_OFS_TEMPORAL_DECIMATION, 8'h19);
    for (int i = 0; i < 10; i++) begin
      strobe(1, 0, 1);
      k = field_keep;
      if (i == 0) check("frame drop", k, 0);
      strobe(1, 1, 1);
      check("frame pair", field_keep, k);
    end
    host.wr(VDSFD_OFS_TEMPORAL_DECIMATION, 8'hD9);
    strobe(1, 0, 1);
    check("odd kept", field_keep, 1);
    strobe(1, 1, 1);
    check("even first", field_keep, 0);
    host.wr(VDSFD_OFS_TEMPORAL_DECIMATION, 8'h80);
    for (int i = 0; i < 4; i++) begin
      strobe(1, i[0], 1);
      check("no decim", field_keep, 1);
    end
    for (int i = 0; i < 32; i++) strobe(1, i[0], 0);
    check("std 525", line_count_standard_flag, 0);
    host.wr(VDSFD_OFS_TEMPORAL_DECIMATION, 8'h9E);
    d = 0;
    for (int i = 0; i < 60; i++) begin
      strobe(1, i[0], 0);
      d += !field_keep;
    end
    check("drops 525", d, 30);
  endtask
  task automatic t_rerst();
    host.wr(VDSFD_OFS_INPUT_FORMAT, 8'h27);
    @(posedge clk);
    #1 {luma_ovf, field_even} = 2'b10;
    repeat (2) @(posedge clk);
    #1 luma_ovf = 1'b0;
    rst_b = 1'b0;
    repeat (2) @(posedge clk);
    #1 rst_b = 1'b1;
    rchk(VDSFD_OFS_DEVICE_STATUS, 32'h0000_0000, "status rerst");
    rchk(VDSFD_OFS_INPUT_FORMAT, 32'h0000_0058, "format rerst");
    rchk(VDSFD_OFS_TEMPORAL_DECIMATION, 32'h0000_0000, "decim rerst");
    check("keep rerst", field_keep, 1);
  endtask

  // Whole run is under two thousand cycles; this leaves a wide margin
  initial begin
    #500_000;
    errors++;
    results();
  end
  initial begin
    {line_stb, line_sync_ok, line_hsync_ok, field_stb, field_even, field_625} = '0;
    {pll_unlock, luma_ovf, chroma_ovf} = '0;
    repeat (8) @(posedge clk);
    #1 rst_b = 1'b1;
    t_reset();
    t_format();
    t_overflow();
    t_sync();
    t_std();
    t_decim();
    t_rerst();
    results();
  end
endmodule

bind vdsfd_regs vdsfd_regs_checker u_chk (.clk(clk), .rst_b(rst_b), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rvalid(reg_rvalid), .reg_addr(reg_addr), .reg_be(reg_be),
  .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .line_stb(line_stb),
  .line_sync_ok(line_sync_ok), .line_hsync_ok(line_hsync_ok), .field_stb(field_stb),
  .field_even(field_even), .field_625(field_625), .pll_unlock(pll_unlock),
  .luma_ovf(luma_ovf), .chroma_ovf(chroma_ovf), .format_auto(format_auto),
  .field_keep(field_keep), .video_present_flag(video_present_flag),
  .horizontal_lock_flag(horizontal_lock_flag), .video_input_index(video_input_index),
  .line_count_standard_flag(line_count_standard_flag), .format_sel(format_sel));
